// File: hdl/asp_fifo.sv
`timescale 1ns/1ps
module asp_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Filling side
   input wire logic in_valid,
   input wire logic [WIDTH-1:0] in_data,
   output logic in_ready,
   // Draining side
   output logic out_valid,
   output logic [WIDTH-1:0] out_data,
   input wire logic out_ready
);

   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [AW:0] wr_ptr;
      logic [AW:0] rd_ptr;
   } asp_fifo_state_t;

   asp_fifo_state_t st_reg;
   asp_fifo_state_t st_next;
   logic [WIDTH-1:0] mem [DEPTH];
   logic full;
   logic empty;
   logic push;
   logic pop;

   // Extra pointer bit tells full from empty
   assign empty = st_reg.wr_ptr == st_reg.rd_ptr;
   assign full = (st_reg.wr_ptr[AW] != st_reg.rd_ptr[AW])
      && (st_reg.wr_ptr[AW-1:0] == st_reg.rd_ptr[AW-1:0]);
   assign in_ready = !full;
   assign out_valid = !empty;
   assign out_data = mem[st_reg.rd_ptr[AW-1:0]];
   assign push = in_valid && !full;
   assign pop = out_ready && !empty;

   always_comb begin
      st_next = st_reg;
      if (push) begin
         st_next.wr_ptr = st_reg.wr_ptr + 1'b1;
      end
      if (pop) begin
         st_next.rd_ptr = st_reg.rd_ptr + 1'b1;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   always_ff @(posedge mclk) begin
      if (push) begin
         mem[st_reg.wr_ptr[AW-1:0]] <= in_data;
      end
   end

endmodule

// File: hdl/asp_serial_port.sv
`timescale 1ns/1ps
// How it works
// (RL1) Clock modes 00, 01, 10 move the serial output on falling serial clock.
// (RL2) Clock mode 11 moves the serial output on rising serial clock.
// (RL3) Serial output is high impedance whenever chip select is high.
// (RL4) Serial clock and input are ignored while chip select is high.
// (RL5) Serial input is sampled on the first 16 falling serial clock edges of a frame.
// (RL6) End-of-conversion goes low on completion; result is then ready to read.
// (RL7) While the DAC load pin is low, DAC outputs follow input registers.
// (RL8) Power-up fills DAC input registers with ones or zeros per select pin.
// (RL9) Select pin also chooses wake-up termination: ground low, reference high.
// (RL10) The master makes the serial clock and keeps it within its maximum rate.
// (RL11) A two-bit clock mode, written serially, picks the output shift edge.
module asp_serial_port (
   // System clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Serial link
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic din,
   output logic dout_o,
   output logic dout_oe,
   output logic eoc_n,
   // Control pins
   input wire logic dac_load_n,
   input wire logic dac_powerup_select,
   // DAC side
   output logic [asp_pkg::DAC_COUNT*asp_pkg::DAC_BITS-1:0] dac_value,
   output logic dac_term_to_ref,
   // Converter front end
   input wire logic [asp_pkg::DAC_BITS-1:0] adc_sample,
   output logic [asp_pkg::CHAN_BITS-1:0] adc_channel
);

   // System clock domain state
   typedef struct packed {
      logic cs_s1;
      logic cs_s2;
      logic load_s1;
      logic load_s2;
      logic sel_s1;
      logic sel_s2;
      logic rx_s1;
      logic rx_s2;
      logic rx_s3;
      logic rd_s1;
      logic rd_s2;
      logic rd_s3;
      asp_pkg::asp_state_t state;
      logic [1:0] init_cnt;
      logic [asp_pkg::DAC_COUNT-1:0][asp_pkg::DAC_BITS-1:0] dac_in;
      logic [asp_pkg::DAC_COUNT-1:0][asp_pkg::DAC_BITS-1:0] dac_out;
      logic term_ref;
      logic [1:0] mode;
      logic [1:0] mode_pend;
      logic mode_upd;
      logic [asp_pkg::CONV_CNT_BITS-1:0] conv_cnt;
      logic [asp_pkg::CHAN_BITS-1:0] chan;
      logic [asp_pkg::DAC_BITS-1:0] sample;
      logic eoc_n;
      logic [asp_pkg::RESULT_BITS-1:0] tx_hold;
      logic tx_valid;
   } asp_sys_t;

   // Link state cleared at every frame start
   typedef struct packed {
      logic [asp_pkg::CNT_BITS-1:0] bit_cnt;
      logic [asp_pkg::FRAME_BITS-1:0] rx_shift;
   } asp_frame_t;

   // Link state that lives across frames
   typedef struct packed {
      logic [asp_pkg::FRAME_BITS-1:0] rx_word;
      logic rx_tgl;
      logic rd_tgl;
   } asp_link_t;

   // Output shifter state, clocked on the selected edge
   typedef struct packed {
      logic loaded;
      logic [asp_pkg::RESULT_BITS-1:0] tx_shift;
      logic dout;
      logic oe;
   } asp_shift_t;

   asp_sys_t sys_reg;
   asp_sys_t sys_next;
   asp_frame_t frm_reg;
   asp_frame_t frm_next;
   asp_link_t lnk_reg;
   asp_link_t lnk_next;
   asp_shift_t sh_reg;
   asp_shift_t sh_next;

   logic frame_rst;
   logic shift_clk;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic [asp_pkg::RESULT_BITS-1:0] fifo_out_data;
   logic fifo_out_ready;
   logic fifo_in_valid;
   logic [asp_pkg::RESULT_BITS-1:0] fifo_in_data;

   function automatic logic [3:0] cmd_of(input logic [asp_pkg::FRAME_BITS-1:0] w);
      cmd_of = w[asp_pkg::CMD_MSB:asp_pkg::CMD_LSB];
   endfunction

   function automatic logic [11:0] data_of(input logic [asp_pkg::FRAME_BITS-1:0] w);
      data_of = w[asp_pkg::DATA_MSB:asp_pkg::DATA_LSB];
   endfunction

   // Link logic is held cleared while deselected
   assign frame_rst = rst | cs_n; // [RL4]

   // Mode only changes while deselected, so the clock select is static per frame
   assign shift_clk = (sys_reg.mode == asp_pkg::MODE_RISE_OUT) ? sclk : ~sclk; // [RL1] [RL2]

   // Receive side: falling serial clock in every mode
   always_comb begin
      frm_next = frm_reg;
      lnk_next = lnk_reg;
      if (frm_reg.bit_cnt != asp_pkg::FRAME_DONE) begin
         frm_next.rx_shift = {frm_reg.rx_shift[asp_pkg::FRAME_BITS-2:0], din}; // [RL5]
         frm_next.bit_cnt = frm_reg.bit_cnt + 1'b1;
      end
      // Word stays still until the next frame completes
      if (frm_reg.bit_cnt == asp_pkg::LAST_BIT) begin
         lnk_next.rx_word = {frm_reg.rx_shift[asp_pkg::FRAME_BITS-2:0], din};
         lnk_next.rx_tgl = !lnk_reg.rx_tgl;
         lnk_next.rd_tgl = !lnk_reg.rd_tgl;
      end
   end

   always_ff @(negedge sclk or posedge frame_rst) begin
      if (frame_rst) begin
         frm_reg <= '0; // [RL4]
      end else begin
         frm_reg <= frm_next; // [RL5]
      end
   end

   always_ff @(negedge sclk or posedge rst) begin
      if (rst) begin
         lnk_reg <= '0;
      end else if (!cs_n) begin
         lnk_reg <= lnk_next; // [RL4]
      end
   end

   // Transmit side: first active edge drives the MSB, later edges shift
   always_comb begin
      sh_next = sh_reg;
      sh_next.oe = 1'b1;
      if (!sh_reg.loaded) begin
         sh_next.loaded = 1'b1;
         sh_next.dout = sys_reg.tx_hold[asp_pkg::RESULT_BITS-1];
         sh_next.tx_shift = {sys_reg.tx_hold[asp_pkg::RESULT_BITS-2:0], 1'b0};
      end else begin
         sh_next.dout = sh_reg.tx_shift[asp_pkg::RESULT_BITS-1];
         sh_next.tx_shift = {sh_reg.tx_shift[asp_pkg::RESULT_BITS-2:0], 1'b0};
      end
   end

   always_ff @(posedge shift_clk or posedge frame_rst) begin
      if (frame_rst) begin
         sh_reg <= '0; // [RL3]
      end else begin
         sh_reg <= sh_next; // [RL1] [RL2]
      end
   end

   // Results queue between the converter and the serial reader
   asp_fifo #(
      .WIDTH(asp_pkg::RESULT_BITS),
      .DEPTH(asp_pkg::FIFO_DEPTH)
   ) u_fifo (
      .mclk(mclk),
      .rst(rst),
      .in_valid(fifo_in_valid),
      .in_data(fifo_in_data),
      .in_ready(fifo_in_ready),
      .out_valid(fifo_out_valid),
      .out_data(fifo_out_data),
      .out_ready(fifo_out_ready)
   );

   assign fifo_in_valid = sys_reg.state == asp_pkg::ST_PUSH;
   assign fifo_in_data = {sys_reg.chan, sys_reg.sample};
   // Hold only reloads while deselected so a frame never sees it change
   assign fifo_out_ready = sys_reg.cs_s2 && !sys_reg.tx_valid
      && sys_reg.rd_s3 == sys_reg.rd_s2;

   always_comb begin
      sys_next = sys_reg;
      sys_next.cs_s1 = cs_n;
      sys_next.cs_s2 = sys_reg.cs_s1;
      sys_next.load_s1 = dac_load_n;
      sys_next.load_s2 = sys_reg.load_s1;
      sys_next.sel_s1 = dac_powerup_select;
      sys_next.sel_s2 = sys_reg.sel_s1;
      sys_next.rx_s1 = lnk_reg.rx_tgl;
      sys_next.rx_s2 = sys_reg.rx_s1;
      sys_next.rx_s3 = sys_reg.rx_s2;
      sys_next.rd_s1 = lnk_reg.rd_tgl;
      sys_next.rd_s2 = sys_reg.rd_s1;
      sys_next.rd_s3 = sys_reg.rd_s2;

      // A finished frame consumes the word that was offered
      if (sys_reg.rd_s3 != sys_reg.rd_s2) begin
         sys_next.tx_valid = 1'b0;
      end else if (fifo_out_ready && fifo_out_valid) begin
         sys_next.tx_hold = fifo_out_data;
         sys_next.tx_valid = 1'b1;
      end

      // New mode applied only between frames
      if (sys_reg.mode_upd && sys_reg.cs_s2) begin
         sys_next.mode = sys_reg.mode_pend; // [RL11]
         sys_next.mode_upd = 1'b0;
      end

      case (sys_reg.state)
         asp_pkg::ST_INIT: begin
            // Wait for the strap to pass its synchroniser
            if (sys_reg.init_cnt == asp_pkg::INIT_WAIT) begin
               for (int i = 0; i < asp_pkg::DAC_COUNT; i++) begin
                  sys_next.dac_in[i] = sys_reg.sel_s2 ? asp_pkg::DAC_ALL_ONES
                     : asp_pkg::DAC_ALL_ZEROS; // [RL8]
               end
               sys_next.dac_out = sys_next.dac_in; // [RL8]
               sys_next.term_ref = sys_reg.sel_s2; // [RL9]
               sys_next.state = asp_pkg::ST_IDLE;
            end else begin
               sys_next.init_cnt = sys_reg.init_cnt + 1'b1;
            end
         end
         asp_pkg::ST_IDLE: begin
         end
         asp_pkg::ST_CONV: begin
            if (sys_reg.conv_cnt == asp_pkg::CONV_CNT_BITS'(asp_pkg::CONV_CYCLES - 1)) begin
               sys_next.sample = adc_sample;
               sys_next.state = asp_pkg::ST_PUSH;
            end else begin
               sys_next.conv_cnt = sys_reg.conv_cnt + 1'b1;
            end
         end
         asp_pkg::ST_PUSH: begin
            // Full queue stalls the converter until a result is read
            if (fifo_in_ready) begin
               sys_next.eoc_n = 1'b0; // [RL6]
               sys_next.state = asp_pkg::ST_IDLE;
            end
         end
         default: begin
            sys_next.state = asp_pkg::ST_IDLE;
         end
      endcase

      // Commands from a completed frame
      if (sys_reg.rx_s3 != sys_reg.rx_s2 && sys_reg.state != asp_pkg::ST_INIT) begin
         if (cmd_of(lnk_reg.rx_word) <= asp_pkg::CMD_DAC_LAST) begin
            sys_next.dac_in[cmd_of(lnk_reg.rx_word)] = data_of(lnk_reg.rx_word);
         end else if (cmd_of(lnk_reg.rx_word) == asp_pkg::CMD_CLOCK_MODE) begin
            sys_next.mode_pend = lnk_reg.rx_word[1:0]; // [RL11]
            sys_next.mode_upd = 1'b1;
         end else if (cmd_of(lnk_reg.rx_word) == asp_pkg::CMD_CONVERT) begin
            if (sys_reg.state == asp_pkg::ST_IDLE) begin
               sys_next.chan = lnk_reg.rx_word[asp_pkg::CHAN_BITS-1:0];
               sys_next.conv_cnt = '0;
               sys_next.eoc_n = 1'b1;
               sys_next.state = asp_pkg::ST_CONV;
            end
         end else if (cmd_of(lnk_reg.rx_word) == asp_pkg::CMD_DAC_UPDATE) begin
            sys_next.dac_out = sys_next.dac_in;
         end
      end

      // Load pin low makes the DAC registers transparent
      if (!sys_reg.load_s2 && sys_reg.state != asp_pkg::ST_INIT) begin
         sys_next.dac_out = sys_next.dac_in; // [RL7]
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         sys_reg <= '0;
         sys_reg.cs_s1 <= 1'b1;
         sys_reg.cs_s2 <= 1'b1;
         sys_reg.load_s1 <= 1'b1;
         sys_reg.load_s2 <= 1'b1;
         sys_reg.state <= asp_pkg::ST_INIT;
         sys_reg.mode <= asp_pkg::MODE_RESET;
         sys_reg.eoc_n <= 1'b1;
      end else begin
         sys_reg <= sys_next;
      end
   end

   assign dout_o = sh_reg.dout;
   assign dout_oe = sh_reg.oe; // [RL3]
   assign eoc_n = sys_reg.eoc_n; // [RL6]
   assign dac_value = sys_reg.dac_out;
   assign dac_term_to_ref = sys_reg.term_ref;
   assign adc_channel = sys_reg.chan;

endmodule

// File: include/asp_pkg.sv
package asp_pkg;

   // Serial frame layout: 4-bit command over 12-bit payload, MSB first
   localparam int FRAME_BITS = 16;
   localparam int CMD_MSB = 15;
   localparam int CMD_LSB = 12;
   localparam int DATA_MSB = 11;
   localparam int DATA_LSB = 0;
   localparam int CNT_BITS = 5;
   localparam logic [4:0] LAST_BIT = 5'h0f;
   localparam logic [4:0] FRAME_DONE = 5'h10;

   // DAC bank
   localparam int DAC_BITS = 12;
   localparam int DAC_COUNT = 8;
   localparam logic [11:0] DAC_ALL_ONES = 12'hfff;
   localparam logic [11:0] DAC_ALL_ZEROS = 12'h000;

   // Commands
   localparam logic [3:0] CMD_DAC_LAST = 4'h7;
   localparam logic [3:0] CMD_CLOCK_MODE = 4'h8;
   localparam logic [3:0] CMD_CONVERT = 4'h9;
   localparam logic [3:0] CMD_DAC_UPDATE = 4'ha;

   // Clock modes; only the last one moves the output on the rising edge
   localparam logic [1:0] MODE_RISE_OUT = 2'h3;
   localparam logic [1:0] MODE_RESET = 2'h0;

   // Result FIFO
   localparam int FIFO_DEPTH = 8;
   localparam int CHAN_BITS = 4;
   localparam int RESULT_BITS = 16;

   // Timing
   localparam int CLK_PERIOD_NS = 20;
   localparam int CONV_TIME_NS = 9000;
   localparam int CONV_CYCLES = CONV_TIME_NS / CLK_PERIOD_NS;
   localparam int CONV_CNT_BITS = 9;
   localparam logic [1:0] INIT_WAIT = 2'h3;

   typedef enum logic [1:0] {
      ST_INIT,
      ST_IDLE,
      ST_CONV,
      ST_PUSH
   } asp_state_t;

endpackage

// File: testbench/adc_dac_serial_pin_interface_tb.sv
`timescale 1ns/1ps
`define CHK(a, e, m) begin checks++; if ((a) !== (e)) begin bad_count++; \
   $display("CHECK FAILED %0t %s", $time, m); end end
module adc_dac_serial_pin_interface_tb;
   logic mclk, rst, dac_load_n, dac_powerup_select;
   logic sclk, cs_n, din, dout_o, dout_oe, eoc_n, dac_term_to_ref;
   logic [95:0] dac_value;
   logic [11:0] adc_sample;
   logic [3:0] adc_channel;
   logic [15:0] rd;
   int bad_count, checks;

   asp_serial_port dut (.mclk, .rst, .sclk, .cs_n, .din, .dout_o, .dout_oe, .eoc_n,
      .dac_load_n, .dac_powerup_select, .dac_value, .dac_term_to_ref, .adc_sample,
      .adc_channel);
   asp_master mst (.sclk, .cs_n, .din, .dout_o, .dout_oe);

   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   task report_and_stop;
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   task do_reset(input logic strap);
      @(posedge mclk);
      rst <= 1'b1;
      dac_powerup_select <= strap;
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      repeat (8) @(posedge mclk);
   endtask

   task t_powerup;
      do_reset(1'b1);
      `CHK(dac_value, {8{12'hfff}}, "ones at power-up")
      `CHK(dac_term_to_ref, 1'b1, "termination to ref")
      do_reset(1'b0);
      `CHK(dac_value, {8{12'h000}}, "zeros at power-up")
      `CHK(dac_term_to_ref, 1'b0, "termination to ground")
      $display("done powerup");
   endtask

   task t_dac;
      mst.frame(16'h2123, 1'b1, 1'b0, rd);
      repeat (10) @(posedge mclk);
      `CHK(dac_value[35:24], 12'h000, "output latched")
      dac_load_n <= 1'b0;
      repeat (5) @(posedge mclk);
      `CHK(dac_value[35:24], 12'h123, "output transparent")
      mst.frame(16'h3456, 1'b0, 1'b0, rd);
      repeat (10) @(posedge mclk);
      `CHK(dac_value[47:36], 12'h000, "deselected frame used")
      `CHK(dout_oe, 1'b0, "dout enabled")
      dac_load_n <= 1'b1;
      repeat (5) @(posedge mclk);
      mst.frame(16'h3456, 1'b1, 1'b0, rd);
      repeat (10) @(posedge mclk);
      `CHK(dac_value[47:36], 12'h000, "output moved while load high")
      mst.frame(16'ha000, 1'b1, 1'b0, rd);
      repeat (10) @(posedge mclk);
      `CHK(dac_value[47:36], 12'h456, "update command not applied")
      $display("done dac");
   endtask

   task t_conv(input logic [1:0] m);
      int n;
      mst.frame({12'h800, 2'b00, m}, 1'b1, 1'b0, rd);
      @(posedge mclk);
      adc_sample <= {m, 10'h2c5};
      mst.frame({12'h900, 2'b01, m}, 1'b1, m == 2'h3, rd);
      n = 0;
      // Sampled away from the launching edge
      while (eoc_n !== 1'b0 && n < 1000) begin
         @(negedge mclk);
         n++;
      end
      `CHK(eoc_n, 1'b0, "no end of conversion")
      `CHK(n > 440, 1'b1, "conversion too short")
      `CHK(adc_channel, {2'b01, m}, "channel")
      repeat (2) @(posedge mclk);
      mst.frame(16'hf000, 1'b1, m == 2'h3, rd);
      `CHK(rd, {2'b01, m, m, 10'h2c5}, "read word")
      $display("done conversion mode %0d", m);
   endtask

   initial begin
      #100000;
      bad_count++;
      report_and_stop;
   end

   initial begin
      rst = 1'b1;
      dac_load_n = 1'b1;
      dac_powerup_select = 1'b1;
      adc_sample = 12'h000;
      bad_count = 0;
      checks = 0;
      t_powerup;
      t_dac;
      for (int m = 0; m < 4; m++) t_conv(m[1:0]);
      report_and_stop;
   end
endmodule

// File: testbench/asp_master.sv
`timescale 1ns/1ps
module asp_master (
   // Driven by the master
   output logic sclk,
   output logic cs_n,
   output logic din,
   // From the device
   input wire logic dout_o,
   input wire logic dout_oe
);
   logic line;

   // Released line shows the inverse, so a late or early sample cannot pass
   assign line = dout_oe ? dout_o : ~dout_o;

   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      din = 1'b0;
   end

   // Clock stands low outside frames; 30 ns period, half high, half low
   task automatic frame(input logic [15:0] w, input logic sel, input logic m3,
      output logic [15:0] rd);
      rd = 16'h0000;
      cs_n = !sel;
      #10;
      // One extra edge pair so modes 00, 01 and 10 can pick up the last bit
      for (int i = 0; i < 17; i++) begin
         if (i < 16) din = w[15-i];
         #5 sclk = 1'b1;
         if (!m3 && i > 0) rd = {rd[14:0], line};
         #15;
         if (m3 && i < 16) rd = {rd[14:0], line};
         sclk = 1'b0;
         #10;
      end
      cs_n = 1'b1;
      din = ~din;
      #200;
   endtask
endmodule

// File: testbench/asp_serial_port_properties.sv
`timescale 1ns/1ps
module asp_serial_port_properties (
   // Clock, reset, link
   input wire logic mclk,
   input wire logic rst,
   input wire logic cs_n,
   input wire logic dout_o,
   input wire logic dout_oe,
   input wire logic eoc_n,
   // Pins and outputs
   input wire logic dac_load_n,
   input wire logic dac_powerup_select,
   input wire logic [95:0] dac_value,
   input wire logic dac_term_to_ref,
   input wire logic [3:0] adc_channel
);
   logic [9:0] hi_cnt_reg;
   logic [2:0] up_cnt_reg;

   // Saturating, so a long idle never wraps into a false short conversion
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         hi_cnt_reg <= 10'h000;
         up_cnt_reg <= 3'h0;
      end else begin
         if (!eoc_n) hi_cnt_reg <= 10'h000;
         else if (hi_cnt_reg != 10'h3ff) hi_cnt_reg <= hi_cnt_reg + 10'h001;
         if (up_cnt_reg != 3'h7) up_cnt_reg <= up_cnt_reg + 3'h1;
      end
   end

   default clocking @(posedge mclk); endclocking
   default disable iff (rst);

   a_oe_off_cs: assert property (cs_n |-> !dout_oe)
      else $error("dout driven while deselected");
   a_oe_holds: assert property ((dout_oe && !cs_n) ##1 !cs_n |-> dout_oe)
      else $error("dout enable dropped inside a frame");
   a_idle_quiet: assert property (cs_n [*2] |-> $stable(dout_o))
      else $error("dout moved while deselected");
   a_conv_time: assert property ($fell(eoc_n) |-> hi_cnt_reg >= 10'h1c2)
      else $error("conversion ended too early");
   a_chan_in_conv: assert property ($changed(adc_channel) |-> eoc_n)
      else $error("channel changed with result flagged");
   a_eoc_holds: assert property ((!eoc_n && cs_n) [*6] |=> !eoc_n)
      else $error("end of conversion dropped without a start");
   a_strap_load: assert property ($fell(rst) |-> ##[3:5]
      (dac_value == {8{{12{dac_powerup_select}}}} && dac_term_to_ref == dac_powerup_select))
      else $error("power-up DAC value or termination wrong");
   a_term_stable: assert property (up_cnt_reg == 3'h7 |-> $stable(dac_term_to_ref))
      else $error("termination changed after power-up");
   a_dac_latched: assert property (
      (dac_load_n && cs_n) [*8] ##0 up_cnt_reg == 3'h7 |-> $stable(dac_value))
      else $error("DAC outputs moved while load high");
endmodule

bind asp_serial_port asp_serial_port_properties chk (.mclk, .rst, .cs_n, .dout_o, .dout_oe,
   .eoc_n, .dac_load_n, .dac_powerup_select, .dac_value, .dac_term_to_ref, .adc_channel);
